// ===== design/eel_pkg.sv
// Package for the edge event line controller: register map, field
// layout, reset values and the bus address-phase carrier.
// Assumes a 32-bit AHB-Lite slave with word-aligned registers.
package eel_pkg;

  // Register byte offsets
  localparam logic [7:0] EEL_OFS_IRQ_MASK = 8'h00;
  localparam logic [7:0] EEL_OFS_EVT_MASK = 8'h04;
  localparam logic [7:0] EEL_OFS_RISE_SEL = 8'h08;
  localparam logic [7:0] EEL_OFS_FALL_SEL = 8'h0c;
  localparam logic [7:0] EEL_OFS_PENDING = 8'h10;
  localparam logic [7:0] EEL_OFS_SRC_SEL0 = 8'h14;
  localparam logic [7:0] EEL_OFS_SRC_SEL3 = 8'h20;
  localparam logic [7:0] EEL_OFS_RAW_LEVEL = 8'h24;

  // Pin selector layout: four fields per word, one byte apart
  localparam int EEL_SEL_W = 6;
  localparam int EEL_SEL_STRIDE = 8;
  localparam int EEL_SEL_PER_WORD = 4;
  localparam int EEL_ADDR_W = 8;

  // Reset values
  localparam logic [31:0] EEL_RST_MASK = 32'h0000_0000;
  localparam logic [31:0] EEL_RST_EDGE = 32'h0000_0000;
  localparam logic [EEL_SEL_W-1:0] EEL_RST_SEL = 6'h00;

  // AHB encodings
  localparam logic [1:0] EEL_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] EEL_HSIZE_WORD = 3'h2;

  // Slave bus phase
  typedef enum logic [1:0] {
    EEL_BUS_IDLE,
    EEL_BUS_WRITE,
    EEL_BUS_READ
  } eel_bus_st_t;

  // Captured address phase
  typedef struct packed {
    logic [EEL_ADDR_W-1:0] addr;
    logic write;
    logic valid;
  } eel_aphase_t;

endpackage

// ===== design/eel_top.sv
// Edge event line controller: 24 edge-detecting lines with per-line
// trigger edges, masks and pending bits, a pin selector per external line, and wakeup output.
// Assumes an AHB-Lite master, pins that may pulse faster than clk_sys,
// and peripheral event levels synchronous to clk_sys.
//
// Behaviour
// - 24 lines raise irq, event, wakeup
// - Per-line rising, falling or both edges
// - Per-line mask blocks only that line
// - Readable pending bit per line
// - Pin edges caught below clock period
// - Any of 38 pins selects each external line
// - Any line can wake from stop
//
// The register offsets and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps

module eel_top import eel_pkg::*; #(
  parameter int N_GPIO = 38,
  parameter int N_EXT = 16,
  parameter int N_INT = 8
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Event sources
  input wire logic [N_GPIO-1:0] gpio_in,
  input wire logic [N_INT-1:0] periph_evt,
  // Requests to the nested_vector_irq_unit and power control
  output logic [N_EXT+N_INT-1:0] irq_req,
  output logic [N_EXT+N_INT-1:0] evt_req,
  output logic wakeup
);

  localparam int NL = N_EXT + N_INT;

  if (NL > 32 || N_EXT > EEL_SEL_PER_WORD * 4 || N_GPIO > (1 << EEL_SEL_W) ||
      N_EXT < 1 || N_INT < 1 || N_GPIO < 1) begin : g_bad_cfg
    $error("eel_top: line or pin count out of range");
  end

  // Reset release through two flops
  logic [1:0] rst_q;
  logic rst_s_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_s_n = rst_q[1];

  // Control registers
  logic [NL-1:0] irq_mask;
  logic [NL-1:0] evt_mask;
  logic [NL-1:0] rise_sel;
  logic [NL-1:0] fall_sel;
  logic [NL-1:0] pending;
  logic [EEL_SEL_W-1:0] src_sel [N_EXT];

  // Selector field of one line in a selector word
  function automatic logic [EEL_SEL_W-1:0] sel_field(input logic [31:0] w, input int k);
    sel_field = w[k*EEL_SEL_STRIDE +: EEL_SEL_W];
  endfunction

  // Decode of a word offset
  function automatic logic hit(input logic [EEL_ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // Edge detection per line
  logic [NL-1:0] rise_ev;
  logic [NL-1:0] fall_ev;
  logic [NL-1:0] raw_level;
  logic [N_EXT-1:0] pin_sel;

  genvar gi;
  for (gi = 0; gi < N_EXT; gi++) begin : g_ext
    logic tog_r;
    logic tog_f;
    logic [2:0] sync_r;
    logic [2:0] sync_f;
    logic [1:0] sync_lv;
    assign pin_sel[gi] = (int'(src_sel[gi]) < N_GPIO) ? gpio_in[src_sel[gi]] : 1'b0;
    always_ff @(posedge pin_sel[gi] or negedge rst_s_n) begin
      if (!rst_s_n) begin
        tog_r <= 1'b0;
      end else begin
        tog_r <= ~tog_r;
      end
    end
    always_ff @(negedge pin_sel[gi] or negedge rst_s_n) begin
      if (!rst_s_n) begin
        tog_f <= 1'b0;
      end else begin
        tog_f <= ~tog_f;
      end
    end
    // Toggles, not levels, cross so a short pulse is never lost
    always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
        sync_r <= 3'h0;
        sync_f <= 3'h0;
        sync_lv <= 2'h0;
      end else if (ce) begin
        sync_r <= {sync_r[1:0], tog_r};
        sync_f <= {sync_f[1:0], tog_f};
        sync_lv <= {sync_lv[0], pin_sel[gi]};
      end
    end
    assign rise_ev[gi] = sync_r[2] ^ sync_r[1];
    assign fall_ev[gi] = sync_f[2] ^ sync_f[1];
    assign raw_level[gi] = sync_lv[1];
  end

  for (gi = 0; gi < N_INT; gi++) begin : g_int
    logic prev;
    always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
        prev <= 1'b0;
      end else if (ce) begin
        prev <= periph_evt[gi];
      end
    end
    assign rise_ev[N_EXT+gi] = periph_evt[gi] & ~prev;
    assign fall_ev[N_EXT+gi] = ~periph_evt[gi] & prev;
    assign raw_level[N_EXT+gi] = periph_evt[gi];
  end

  logic [NL-1:0] trig;
  assign trig = (rise_ev & rise_sel) | (fall_ev & fall_sel);

  // AHB-Lite slave
  eel_aphase_t aph;
  eel_bus_st_t bus_st;
  logic take;
  logic wr_go;
  logic [EEL_ADDR_W-1:0] wa;
  assign take = hsel & hready & htrans[1];
  // Write data follows its address phase by one cycle
  assign wr_go = (bus_st == EEL_BUS_WRITE);
  assign wa = aph.addr;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      aph <= '0;
      bus_st <= EEL_BUS_IDLE;
      hreadyout <= 1'b1;
    end else if (ce) begin
      case (bus_st)
        EEL_BUS_READ: begin
          // One wait state lets a read see a write just finished
          bus_st <= EEL_BUS_IDLE;
          hreadyout <= 1'b1;
        end
        default: begin
          if (take) begin
            aph <= '{addr: haddr[EEL_ADDR_W-1:0], write: hwrite, valid: 1'b1};
            bus_st <= hwrite ? EEL_BUS_WRITE : EEL_BUS_READ;
            hreadyout <= hwrite;
          end else begin
            bus_st <= EEL_BUS_IDLE;
          end
        end
      endcase
    end
  end

  // Read mux, unmapped offsets read zero
  logic [31:0] rd_word;
  logic [31:0] sel_word [4];
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      sel_word[w] = 32'h0;
      for (int k = 0; k < EEL_SEL_PER_WORD; k++) begin
        if (w * EEL_SEL_PER_WORD + k < N_EXT) begin
          sel_word[w][k*EEL_SEL_STRIDE +: EEL_SEL_W] = src_sel[w*EEL_SEL_PER_WORD+k];
        end
      end
    end
  end

  assign rd_word =
    hit(wa, EEL_OFS_IRQ_MASK) ? 32'(irq_mask) :
    hit(wa, EEL_OFS_EVT_MASK) ? 32'(evt_mask) :
    hit(wa, EEL_OFS_RISE_SEL) ? 32'(rise_sel) :
    hit(wa, EEL_OFS_FALL_SEL) ? 32'(fall_sel) :
    hit(wa, EEL_OFS_PENDING) ? 32'(pending) :
    hit(wa, EEL_OFS_RAW_LEVEL) ? 32'(raw_level) :
    (wa >= EEL_OFS_SRC_SEL0 && wa <= EEL_OFS_SRC_SEL3 && wa[1:0] == 2'h0) ?
      sel_word[2'(((wa - EEL_OFS_SRC_SEL0) >> 2))] : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      hrdata <= 32'h0;
      hresp <= 1'b0;
    end else if (ce && bus_st == EEL_BUS_READ) begin
      hrdata <= rd_word;
    end
  end

  // Register writes
  logic wr_irq_mask;
  logic wr_evt_mask;
  logic wr_rise;
  logic wr_fall;
  logic wr_pend;
  // Decoded once so every register sees the same strobe
  assign wr_irq_mask = wr_go && hit(wa, EEL_OFS_IRQ_MASK);
  assign wr_evt_mask = wr_go && hit(wa, EEL_OFS_EVT_MASK);
  assign wr_rise = wr_go && hit(wa, EEL_OFS_RISE_SEL);
  assign wr_fall = wr_go && hit(wa, EEL_OFS_FALL_SEL);
  assign wr_pend = wr_go && hit(wa, EEL_OFS_PENDING);
  logic [NL-1:0] clr_mask;
  logic [NL-1:0] set_pend;
  logic [NL-1:0] next_pending;
  assign clr_mask = wr_pend ? hwdata[NL-1:0] : '0;
  assign set_pend = trig & irq_mask;
  assign next_pending = (pending & ~clr_mask) | set_pend;

  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      irq_mask <= EEL_RST_MASK[NL-1:0];
      evt_mask <= EEL_RST_MASK[NL-1:0];
      rise_sel <= EEL_RST_EDGE[NL-1:0];
      fall_sel <= EEL_RST_EDGE[NL-1:0];
      pending <= '0;
    end else if (ce) begin
      pending <= next_pending;
      if (wr_irq_mask) begin
        irq_mask <= hwdata[NL-1:0];
      end
      if (wr_evt_mask) begin
        evt_mask <= hwdata[NL-1:0];
      end
      if (wr_rise) begin
        rise_sel <= hwdata[NL-1:0];
      end
      if (wr_fall) begin
        fall_sel <= hwdata[NL-1:0];
      end
    end
  end

  for (gi = 0; gi < N_EXT; gi++) begin : g_sel
    localparam logic [7:0] SEL_OFS = 8'(EEL_OFS_SRC_SEL0 + 4 * (gi / EEL_SEL_PER_WORD));
    always_ff @(posedge clk_sys or negedge rst_s_n) begin
      if (!rst_s_n) begin
        src_sel[gi] <= EEL_RST_SEL;
      end else if (ce && wr_go && hit(wa, SEL_OFS)) begin
        src_sel[gi] <= sel_field(hwdata, gi % EEL_SEL_PER_WORD);
      end
    end
  end

  // Requests out
  logic [NL-1:0] next_irq_req;
  logic [NL-1:0] next_evt_req;
  logic next_wakeup;
  assign next_irq_req = next_pending & irq_mask;
  assign next_evt_req = trig & evt_mask;
  assign next_wakeup = |(trig & (irq_mask | evt_mask));
  // Registered so no output glitches on pin edges
  always_ff @(posedge clk_sys or negedge rst_s_n) begin
    if (!rst_s_n) begin
      irq_req <= '0;
      evt_req <= '0;
      wakeup <= 1'b0;
    end else if (ce) begin
      irq_req <= next_irq_req;
      evt_req <= next_evt_req;
      wakeup <= next_wakeup;
    end
  end

endmodule // eel_top

// ===== tb/eel_sva.sv
// Port assertions for the edge event line controller.
// Assumes one slave, so hready follows hreadyout.
`timescale 1ns/1ps
module eel_sva #(
  parameter int N_EXT = 16,
  parameter int N_INT = 8
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Requests
  input wire logic [N_EXT+N_INT-1:0] irq_req,
  input wire logic [N_EXT+N_INT-1:0] evt_req,
  input wire logic wakeup
);
  logic [2:0] wr_d;
  wire logic take = hsel && hready && htrans[1] && ce;
  // A clear or mask write may lower a request some edges later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_d <= 3'h0;
    end else begin
      wr_d <= {wr_d[1:0], take && hwrite};
    end
  end
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_resp_okay: assert property (take |=> !hresp ##1 !hresp)
    else $error("bad response");
  a_rdata_hold: assert property ($changed(hrdata) |-> !$past(hreadyout))
    else $error("read data moved");
  a_evt_wake: assert property (|evt_req |-> wakeup)
    else $error("event without wakeup");
  a_irq_hold: assert property (|($past(irq_req) & ~irq_req) |-> |wr_d)
    else $error("request dropped alone");
  a_irq_rise: assert property (|(irq_req & ~$past(irq_req)) |-> wakeup || |wr_d)
    else $error("request rose without wakeup");
  a_ce_freeze: assert property (!ce |=> $stable(irq_req) && $stable(hreadyout))
    else $error("state moved with ce low");
endmodule // eel_sva
bind eel_top eel_sva #(.N_EXT(N_EXT), .N_INT(N_INT)) u_eel_sva (.clk_sys(clk_sys),
  .rst_n(rst_n), .ce(ce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq_req(irq_req),
  .evt_req(evt_req), .wakeup(wakeup));

// ===== tb/eel_src_model.sv
// Pin source model for the line controller.
// Assumes the bench commands every pin change.
`timescale 1ns/1ps
module eel_src_model #(parameter int N_GPIO = 38) (
  // Pins
  output logic [N_GPIO-1:0] gpio
);
  initial gpio = '0;
  // Off the clock edge; set holds until told, pulse drops after 3 ns
  task automatic set(input int p, input logic v);
    #5 gpio[p] = v;
  endtask
  task automatic pulse(input int p);
    #5 gpio[p] = 1'b1;
    #3 gpio[p] = 1'b0;
  endtask
endmodule // eel_src_model

// ===== tb/tb_eel_top.sv
// Bench for the edge event line controller.
// Assumes the pin model and the bound checker.
`timescale 1ns/1ps
module tb_eel_top import eel_pkg::*; ;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic rd_ph = 1'b0;
  logic [7:0] periph_evt = 8'h00;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, wakeup;
  wire logic [23:0] irq_req, evt_req;
  wire logic [37:0] gpio_in;
  logic [31:0] expq[$];
  int n_fail = 0, checks = 0, n_wake = 0, n_evt = 0;
  always #10 clk_sys = ~clk_sys;
  eel_src_model pins (.gpio(gpio_in));
  eel_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(EEL_HSIZE_WORD), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .gpio_in(gpio_in), .periph_evt(periph_evt), .irq_req(irq_req), .evt_req(evt_req),
    .wakeup(wakeup));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic w = 1'b1);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= EEL_HTRANS_NONSEQ;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    wr(a, 32'h0, 1'b0);
  endtask
  // Result side: oldest note against each read
  always @(posedge clk_sys) begin
    if (wakeup === 1'b1) n_wake++;
    if (evt_req[17] === 1'b1) n_evt++;
    if (rd_ph && hreadyout) chk(hrdata, expq.pop_front());
    if (hreadyout) rd_ph = htrans[1] && !hwrite;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    int l, p;
    logic [1:0] m;
    void'($urandom(32'heb9f));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(EEL_OFS_PENDING, 32'h0);
    rd(EEL_OFS_IRQ_MASK, EEL_RST_MASK);
    for (int t = 0; t < 6; t++) begin
      l = $urandom % 16;
      p = (t == 0) ? 37 : $urandom % 38;
      m = 2'(t % 3 + 1);
      wr(EEL_OFS_SRC_SEL0 + 8'(4 * (l / 4)), 32'(p) << (8 * (l % 4)));
      rd(EEL_OFS_SRC_SEL0 + 8'(4 * (l / 4)), 32'(p) << (8 * (l % 4)));
      wr(EEL_OFS_RISE_SEL, 32'(m[0]) << l);
      wr(EEL_OFS_FALL_SEL, 32'(m[1]) << l);
      wr(EEL_OFS_IRQ_MASK, 32'h1 << l);
      wr(EEL_OFS_PENDING, 32'h00ff_ffff);
      pins.set(p, 1'b1);
      repeat (8) @(posedge clk_sys);
      rd(EEL_OFS_PENDING, 32'(m[0]) << l);
      wr(EEL_OFS_PENDING, 32'h0);
      rd(EEL_OFS_PENDING, 32'(m[0]) << l);
      wr(EEL_OFS_PENDING, 32'h00ff_ffff);
      pins.set(p, 1'b0);
      repeat (8) @(posedge clk_sys);
      rd(EEL_OFS_PENDING, 32'(m[1]) << l);
      wr(EEL_OFS_PENDING, 32'h00ff_ffff);
      pins.pulse(p);
      repeat (8) @(posedge clk_sys);
      rd(EEL_OFS_PENDING, 32'h1 << l);
      chk(32'(irq_req), 32'h1 << l);
      wr(EEL_OFS_PENDING, 32'h00ff_ffff);
      $display("trial %0d done", t);
    end
    ce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ce <= 1'b1;
    wr(EEL_OFS_IRQ_MASK, 32'h0001_0000);
    wr(EEL_OFS_EVT_MASK, 32'h0002_0000);
    wr(EEL_OFS_RISE_SEL, 32'h0003_0000);
    wr(EEL_OFS_FALL_SEL, 32'h0);
    n_wake = 0;
    n_evt = 0;
    periph_evt <= 8'h03;
    repeat (4) @(posedge clk_sys);
    rd(EEL_OFS_PENDING, 32'h0001_0000);
    chk(n_wake, 1);
    chk(n_evt, 1);
    rd(EEL_OFS_RAW_LEVEL, 32'h0003_0000);
    wr(8'h30, $urandom);
    rd(8'h30, 32'h0);
    $display("internal and map done");
    repeat (2) @(posedge clk_sys);
    final_report();
  end
  // Whole run is far below this span
  initial begin
    #200us;
    n_fail++;
    final_report();
  end
endmodule // tb_eel_top
